// File: trgcb_bank.sv
// trackpad gesture configuration bank: gesture enables, electrode map,
// per-channel threshold offsets, virtual sensor counts, engineering word,
// per-channel auto-tuning compensation words
// assumes a byte-addressed register port driven from clk_sys logic
//
// Summary of operation
// - single-finger word bits 15..12 enable swipe-and-hold Y-,Y+,X-,X+, bits 11..8 plain swipes.
// - single-finger bit 4 palm, 3 press-and-hold, 2 triple, 1 double, 0 single tap; 7..5 unused.
// - two-finger word bits 7..0 enable hscroll, vscroll, zoom out/in, hold, triple, double, single.
// - forty-five one-byte electrode map entries follow one another, then a reserved zero byte.
// - each of 506 channels holds a signed byte added to its touch threshold multiplier.
// - virtual count word holds wheels in 15..12, sliders in 11..8, buttons in 7..0.
// - engineering word bit 0 enables oscillator stepping, bits 10..9 show oscillator status.
// - per-channel compensation word at two-byte stride: divider 14..10, value 9..0, bit 15 zero.
`timescale 1ns/1ps
module trgcb_bank
  import trgcb_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWrData,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [DATA_W-1:0]     regRdData,
  output logic                       regRdValid,
  input  wire logic [1:0]            oscStatus,
  input  wire logic [SF_GEST_W-1:0]  sfGestDetect,
  input  wire logic [TF_GEST_W-1:0]  tfGestDetect,
  output logic      [SF_GEST_W-1:0]  sfGestReport,
  output logic      [TF_GEST_W-1:0]  tfGestReport,
  output logic                       oscStepEn,
  output logic      [3:0]            wheelCount,
  output logic      [3:0]            sliderCount,
  output logic      [7:0]            buttonCount,
  input  wire logic [MAP_IDX_W-1:0]  mapSel,
  output logic      [7:0]            mapEntry,
  input  wire logic [CH_IDX_W-1:0]   chanSel,
  output logic signed [7:0]          chanThrAdj,
  output logic      [4:0]            chanCompDiv,
  output logic      [9:0]            chanCompVal
);
  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic [15:0]          mapOff;
  logic [15:0]          thrOff;
  logic [15:0]          cmpOff;
  logic [MAP_IDX_W-1:0] mapIdx;
  logic [CH_IDX_W-1:0]  thrIdx;
  logic [CH_IDX_W-1:0]  cmpIdx;
  logic                 hitSf;
  logic                 hitTf;
  logic                 hitMap;
  logic                 hitRsvd;
  logic                 hitThr;
  logic                 hitVs;
  logic                 hitEng;
  logic                 hitCmp;

  always_comb begin
    mapOff  = regAddr - MAP_BASE;
    thrOff  = regAddr - THR_BASE;
    cmpOff  = regAddr - COMP_BASE;
    mapIdx  = mapOff[MAP_IDX_W-1:0];
    thrIdx  = thrOff[CH_IDX_W-1:0];
    cmpIdx  = cmpOff[CH_IDX_W:1];
    hitSf   = (regAddr == SF_ADDR);
    hitTf   = (regAddr == TF_ADDR);
    hitMap  = (regAddr >= MAP_BASE) && (regAddr <= MAP_LAST);
    hitRsvd = (regAddr == MAP_RSVD);
    hitThr  = (regAddr >= THR_BASE) && (regAddr <= THR_LAST);
    hitVs   = (regAddr == VS_ADDR);
    hitEng  = (regAddr == ENG_ADDR);
    hitCmp  = (regAddr >= COMP_BASE) && (regAddr <= COMP_LAST) && !cmpOff[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // word registers
  logic [15:0] sfEnable_r;
  logic [15:0] sfEnable_nxt;
  logic [15:0] tfEnable_r;
  logic [15:0] tfEnable_nxt;
  logic [15:0] vsCount_r;
  logic [15:0] vsCount_nxt;
  logic        stepEn_r;
  logic        stepEn_nxt;

  always_comb begin
    sfEnable_nxt = sfEnable_r;
    tfEnable_nxt = tfEnable_r;
    vsCount_nxt  = vsCount_r;
    stepEn_nxt   = stepEn_r;
    if (regWr && hitSf) begin
      sfEnable_nxt = regWrData & SF_MASK;
    end
    if (regWr && hitTf) begin
      tfEnable_nxt = regWrData & TF_MASK;
    end
    if (regWr && hitVs) begin
      vsCount_nxt = regWrData & VS_MASK;
    end
    if (regWr && hitEng) begin
      stepEn_nxt = regWrData[ENG_STEP_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sfEnable_r <= WORD_RESET;
      tfEnable_r <= WORD_RESET;
      vsCount_r  <= WORD_RESET;
      stepEn_r   <= 1'b0;
    end else begin
      sfEnable_r <= sfEnable_nxt;
      tfEnable_r <= tfEnable_nxt;
      vsCount_r  <= vsCount_nxt;
      stepEn_r   <= stepEn_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tables
  logic [7:0]  mapTab_r [MAP_CNT];
  logic [7:0]  thrTab_r [CH_CNT];
  logic [15:0] cmpTab_r [CH_CNT];

  genvar gi;
  generate
    for (gi = 0; gi < CH_CNT; gi++) begin : g_chan
      logic [7:0]  thr_nxt;
      logic [15:0] cmp_nxt;
      always_comb begin
        thr_nxt = thrTab_r[gi];
        cmp_nxt = cmpTab_r[gi];
        if (regWr && hitThr && (thrIdx == CH_IDX_W'(gi))) begin
          thr_nxt = regWrData[7:0];
        end
        if (regWr && hitCmp && (cmpIdx == CH_IDX_W'(gi))) begin
          cmp_nxt = regWrData & COMP_MASK;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          thrTab_r[gi] <= BYTE_RESET;
          cmpTab_r[gi] <= WORD_RESET;
        end else begin
          thrTab_r[gi] <= thr_nxt;
          cmpTab_r[gi] <= cmp_nxt;
        end
      end
      if (gi < MAP_CNT) begin : g_map
        logic [7:0] map_nxt;
        always_comb begin
          map_nxt = mapTab_r[gi];
          if (regWr && hitMap && (mapIdx == MAP_IDX_W'(gi))
              && (regWrData[7:0] != MAP_FORBID)) begin
            map_nxt = regWrData[7:0];
          end
        end
        always_ff @(posedge clk_sys) begin
          if (sys_rst) begin
            mapTab_r[gi] <= BYTE_RESET;
          end else begin
            mapTab_r[gi] <= map_nxt;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path and registered outputs
  logic [15:0] rdMux;
  logic [15:0] engWord;
  logic [15:0] rdData_nxt;
  logic        rdValid_nxt;
  logic [7:0]  mapOut_nxt;
  logic [7:0]  thrOut_nxt;
  logic [15:0] cmpOut_nxt;

  always_comb begin
    engWord = WORD_RESET;
    engWord[ENG_STEP_BIT] = stepEn_r;
    engWord[ENG_OSC_MSB:ENG_OSC_LSB] = oscStatus;
    rdMux = WORD_RESET;
    if (hitSf) begin
      rdMux = sfEnable_r;
    end else if (hitTf) begin
      rdMux = tfEnable_r;
    end else if (hitMap) begin
      rdMux = {8'h00, mapTab_r[mapIdx]};
    end else if (hitRsvd) begin
      rdMux = WORD_RESET;
    end else if (hitThr) begin
      rdMux = {8'h00, thrTab_r[thrIdx]};
    end else if (hitVs) begin
      rdMux = vsCount_r;
    end else if (hitEng) begin
      rdMux = engWord;
    end else if (hitCmp) begin
      rdMux = cmpTab_r[cmpIdx];
    end
    rdData_nxt  = regRd ? rdMux : WORD_RESET;
    rdValid_nxt = regRd;
    mapOut_nxt  = (mapSel < MAP_IDX_W'(MAP_CNT)) ? mapTab_r[mapSel] : BYTE_RESET;
    thrOut_nxt  = (chanSel < CH_IDX_W'(CH_CNT)) ? thrTab_r[chanSel] : BYTE_RESET;
    cmpOut_nxt  = (chanSel < CH_IDX_W'(CH_CNT)) ? cmpTab_r[chanSel] : WORD_RESET;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdData   <= WORD_RESET;
      regRdValid  <= 1'b0;
      mapEntry    <= BYTE_RESET;
      chanThrAdj  <= BYTE_RESET;
      chanCompDiv <= '0;
      chanCompVal <= '0;
      oscStepEn   <= 1'b0;
      wheelCount  <= '0;
      sliderCount <= '0;
      buttonCount <= '0;
    end else begin
      regRdData   <= rdData_nxt;
      regRdValid  <= rdValid_nxt;
      mapEntry    <= mapOut_nxt;
      chanThrAdj  <= thrOut_nxt;
      chanCompDiv <= cmpOut_nxt[CMP_DIV_MSB:CMP_DIV_LSB];
      chanCompVal <= cmpOut_nxt[CMP_VAL_MSB:CMP_VAL_LSB];
      oscStepEn   <= stepEn_nxt;
      wheelCount  <= vsCount_nxt[VS_WHL_MSB:VS_WHL_LSB];
      sliderCount <= vsCount_nxt[VS_SLD_MSB:VS_SLD_LSB];
      buttonCount <= vsCount_nxt[VS_BTN_MSB:VS_BTN_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gesture gating
  trgcb_gate #(.W(SF_GEST_W)) u_sfGate (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .enable   (sfEnable_r),
    .detect   (sfGestDetect),
    .reported (sfGestReport)
  );

  trgcb_gate #(.W(TF_GEST_W)) u_tfGate (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .enable   (tfEnable_r[TF_GEST_W-1:0]),
    .detect   (tfGestDetect),
    .reported (tfGestReport)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence wrAt(logic [15:0] a);
    regWr && !regRd && (regAddr == a);
  endsequence

  sequence rdAt(logic [15:0] a);
    regRd && !regWr && (regAddr == a);
  endsequence

  sequence noWr;
    !regWr;
  endsequence

  sfWrite_mask_a: assert property (wrAt(SF_ADDR) ##1 noWr ##1 rdAt(SF_ADDR)
    |=> regRdData == ($past(regWrData, 3) & SF_MASK))
    else $error("single finger word readback wrong");
  sfUnused_zero_a: assert property (regRdValid && $past(hitSf)
    |-> regRdData[7:5] == 3'h0)
    else $error("single finger unused bits not zero");
  tfWrite_mask_a: assert property (wrAt(TF_ADDR) ##1 noWr ##1 rdAt(TF_ADDR)
    |=> regRdData == ($past(regWrData, 3) & TF_MASK))
    else $error("two finger word readback wrong");
  mapRsvd_zero_a: assert property (rdAt(MAP_RSVD) |=> regRdData == WORD_RESET)
    else $error("reserved map byte not zero");
  mapForbid_keep_a: assert property (regWr && hitMap && regWrData[7:0] == MAP_FORBID
    |=> mapTab_r[$past(mapIdx)] == $past(mapTab_r[mapIdx]))
    else $error("forbidden map value was stored");
  thrStore_a: assert property (regWr && hitThr
    |=> thrTab_r[$past(thrIdx)] == $past(regWrData[7:0]))
    else $error("threshold byte not stored");
  vsFields_a: assert property (wrAt(VS_ADDR) |=> buttonCount == $past(regWrData[7:0])
    && sliderCount == $past(regWrData[11:8])
    && wheelCount == $past(regWrData[15:12]))
    else $error("virtual counts not split right");
  engRead_a: assert property (rdAt(ENG_ADDR) |=> regRdData ==
    {5'h00, $past(oscStatus), 8'h00, oscStepEn})
    else $error("engineering word read wrong");
  engUnused_zero_a: assert property (regRdValid && $past(hitEng)
    |-> regRdData[15:11] == 5'h00 && regRdData[8:1] == 8'h00)
    else $error("engineering unused bits not zero");
  cmpTop_zero_a: assert property (regRdValid && $past(hitCmp) |-> !regRdData[15])
    else $error("compensation bit 15 not zero");
endmodule

// File: trgcb_gate.sv
// gesture report gate: passes a detected gesture only when enabled
// assumes detect pulses come from logic on clk_sys
`timescale 1ns/1ps
module trgcb_gate #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] enable,
  input  wire logic [W-1:0] detect,
  output logic      [W-1:0] reported
);
  logic [W-1:0] reported_nxt;

  always_comb begin
    reported_nxt = detect & enable;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reported <= '0;
    end else begin
      reported <= reported_nxt;
    end
  end

  gateBlock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 ((reported & ~$past(enable)) == '0))
    else $error("disabled gesture was reported");
endmodule

// File: trgcb_host.sv
// host model: drives the byte-addressed register port of the bank
// assumes the bank samples its strobes on the rising edge of clk_sys
`timescale 1ns/1ps
module trgcb_host
  import trgcb_pkg::*;
(
  input  wire logic              clk_sys,
  output logic      [ADDR_W-1:0] regAddr,
  output logic      [DATA_W-1:0] regWrData,
  output logic                   regWr,
  output logic                   regRd,
  input  wire logic [DATA_W-1:0] regRdData,
  input  wire logic              regRdValid
);
  int unsigned gap;
  initial begin
    gap = 0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one write; a real host keeps 0x2c out of the map, only a scenario asks it
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr     <= 1'b0;
    regAddr   <= ~a;
    regWrData <= ~d;
  endtask
  // one read; data taken once the answer cycle has settled
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
    v = regRdValid;
  endtask
endmodule

// File: trgcb_pkg.sv
// constants for the trackpad gesture configuration bank
// assumes a byte-addressed 16-bit register space and one system clock
package trgcb_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 16;
  localparam int          SF_GEST_W    = 16;
  localparam int          TF_GEST_W    = 8;
  localparam int          MAP_CNT      = 45;
  localparam int          CH_CNT       = 506;
  localparam int          MAP_IDX_W    = 6;
  localparam int          CH_IDX_W     = 9;
  localparam logic [15:0] SF_ADDR      = 16'h11f6;
  localparam logic [15:0] TF_ADDR      = 16'h11f8;
  localparam logic [15:0] MAP_BASE     = 16'h1218;
  localparam logic [15:0] MAP_LAST     = 16'h1244;
  localparam logic [15:0] MAP_RSVD     = 16'h1245;
  localparam logic [15:0] THR_BASE     = 16'h12f6;
  localparam logic [15:0] THR_LAST     = 16'h14ef;
  localparam logic [15:0] VS_ADDR      = 16'h14f0;
  localparam logic [15:0] ENG_ADDR     = 16'h2000;
  localparam logic [15:0] COMP_BASE    = 16'hd000;
  localparam logic [15:0] COMP_LAST    = 16'hd3f2;
  localparam logic [15:0] SF_MASK      = 16'hff1f;
  localparam logic [15:0] TF_MASK      = 16'h00ff;
  localparam logic [15:0] VS_MASK      = 16'hffff;
  localparam logic [15:0] COMP_MASK    = 16'h7fff;
  localparam logic [7:0]  MAP_FORBID   = 8'h2c;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam int          ENG_STEP_BIT = 0;
  localparam int          ENG_OSC_LSB  = 9;
  localparam int          ENG_OSC_MSB  = 10;
  localparam int          VS_WHL_MSB   = 15;
  localparam int          VS_WHL_LSB   = 12;
  localparam int          VS_SLD_MSB   = 11;
  localparam int          VS_SLD_LSB   = 8;
  localparam int          VS_BTN_MSB   = 7;
  localparam int          VS_BTN_LSB   = 0;
  localparam int          CMP_DIV_MSB  = 14;
  localparam int          CMP_DIV_LSB  = 10;
  localparam int          CMP_VAL_MSB  = 9;
  localparam int          CMP_VAL_LSB  = 0;
endpackage

// File: trgcb_tb.sv
// testbench: register port through the host model, gesture and table paths
// assumes trgcb_pkg and the host model are compiled first
`timescale 1ns/1ps
module tb
  import trgcb_pkg::*;
;
  logic              clk_sys;
  logic              sys_rst;
  logic [15:0]       regAddr;
  logic [15:0]       regWrData;
  logic              regWr;
  logic              regRd;
  logic [15:0]       regRdData;
  logic              regRdValid;
  logic [1:0]        oscStatus;
  logic [15:0]       sfGestDetect;
  logic [7:0]        tfGestDetect;
  logic [15:0]       sfGestReport;
  logic [7:0]        tfGestReport;
  logic              oscStepEn;
  logic [3:0]        wheelCount;
  logic [3:0]        sliderCount;
  logic [7:0]        buttonCount;
  logic [5:0]        mapSel;
  logic [7:0]        mapEntry;
  logic [8:0]        chanSel;
  logic signed [7:0] chanThrAdj;
  logic [4:0]        chanCompDiv;
  logic [9:0]        chanCompVal;
  int                errTotal;
  int                samplesChecked;
  int                cycles;

  trgcb_bank i_trgcb_bank (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .regRdValid(regRdValid), .oscStatus(oscStatus), .sfGestDetect(sfGestDetect),
    .tfGestDetect(tfGestDetect), .sfGestReport(sfGestReport), .tfGestReport(tfGestReport),
    .oscStepEn(oscStepEn), .wheelCount(wheelCount), .sliderCount(sliderCount),
    .buttonCount(buttonCount), .mapSel(mapSel), .mapEntry(mapEntry), .chanSel(chanSel),
    .chanThrAdj(chanThrAdj), .chanCompDiv(chanCompDiv), .chanCompVal(chanCompVal));
  trgcb_host i_trgcb_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid));
  ////////////////////////////////////////////////////////////////////////////////
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errTotal++;
      wrapUp();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samplesChecked++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    i_trgcb_host.rd(a, d, v);
    chk(d, e);
    chk({15'h0, v}, 16'h0001);
  endtask
  task automatic peek(input logic [5:0] m, input logic [8:0] c);
    @(posedge clk_sys);
    mapSel  <= m;
    chanSel <= c;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic gest(input logic [15:0] sd, input logic [7:0] td);
    @(posedge clk_sys);
    sfGestDetect <= sd;
    tfGestDetect <= td;
    @(posedge clk_sys);
    sfGestDetect <= 16'h0000;
    tfGestDetect <= 8'h00;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic scnReset();
    rdc(SF_ADDR, WORD_RESET);
    rdc(TF_ADDR, WORD_RESET);
    rdc(MAP_RSVD, WORD_RESET);
    rdc(THR_LAST, WORD_RESET);
    rdc(VS_ADDR, WORD_RESET);
    rdc(ENG_ADDR, WORD_RESET);
    rdc(COMP_LAST, WORD_RESET);
    rdc(16'h3000, WORD_RESET);
  endtask
  task automatic scnGesture();
    i_trgcb_host.wr(SF_ADDR, 16'hffff);
    rdc(SF_ADDR, 16'hff1f);
    i_trgcb_host.wr(TF_ADDR, 16'hffff);
    rdc(TF_ADDR, 16'h00ff);
    for (int i = 0; i < 16; i++) begin
      gest(16'h0001 << i, 8'h01 << (i % 8));
      chk(sfGestReport, (16'h0001 << i) & 16'hff1f);
      chk({8'h00, tfGestReport}, {8'h00, 8'h01 << (i % 8)});
    end
    i_trgcb_host.wr(SF_ADDR, 16'ha5f5);
    i_trgcb_host.wr(TF_ADDR, 16'h005a);
    gest(16'hffff, 8'hff);
    chk(sfGestReport, 16'ha515);
    chk({8'h00, tfGestReport}, 16'h005a);
    @(posedge clk_sys);
    #1;
    chk(sfGestReport, 16'h0000);
  endtask
  task automatic scnMap();
    i_trgcb_host.wr(MAP_BASE, 16'hff11);
    i_trgcb_host.wr(MAP_LAST, 16'h002b);
    i_trgcb_host.wr(MAP_LAST, 16'h002c);
    i_trgcb_host.wr(MAP_RSVD, 16'h00ff);
    rdc(MAP_BASE, 16'h0011);
    rdc(MAP_LAST, 16'h002b);
    rdc(MAP_RSVD, 16'h0000);
    peek(6'h2c, 9'h000);
    chk({8'h00, mapEntry}, 16'h002b);
  endtask
  task automatic scnThr();
    i_trgcb_host.gap = 2;
    i_trgcb_host.wr(THR_BASE, 16'h0080);
    i_trgcb_host.wr(THR_LAST, 16'h007f);
    i_trgcb_host.gap = 0;
    rdc(THR_BASE, 16'h0080);
    rdc(THR_LAST, 16'h007f);
    peek(6'h00, 9'h1f9);
    chk({8'h00, mapEntry}, 16'h0011);
    chk({8'h00, chanThrAdj}, 16'h007f);
    peek(6'h2d, 9'h000);
    chk({8'h00, mapEntry}, 16'h0000);
    chk({8'h00, chanThrAdj}, 16'h0080);
  endtask
  task automatic scnCounts();
    i_trgcb_host.wr(VS_ADDR, 16'h9c37);
    rdc(VS_ADDR, 16'h9c37);
    chk({wheelCount, sliderCount, buttonCount}, 16'h9c37);
  endtask
  task automatic scnEng();
    @(posedge clk_sys);
    oscStatus <= 2'h2;
    i_trgcb_host.wr(ENG_ADDR, 16'hffff);
    rdc(ENG_ADDR, 16'h0401);
    chk({15'h0, oscStepEn}, 16'h0001);
    @(posedge clk_sys);
    oscStatus <= 2'h1;
    i_trgcb_host.wr(ENG_ADDR, 16'hfffe);
    rdc(ENG_ADDR, 16'h0200);
    chk({15'h0, oscStepEn}, 16'h0000);
  endtask
  task automatic scnComp();
    i_trgcb_host.wr(COMP_BASE, 16'hffff);
    i_trgcb_host.wr(COMP_LAST, 16'h5a5a);
    i_trgcb_host.wr(16'hd001, 16'h1234);
    rdc(COMP_BASE, 16'h7fff);
    rdc(16'hd002, 16'h0000);
    rdc(COMP_LAST, 16'h5a5a);
    peek(6'h00, 9'h1f9);
    chk({1'b0, chanCompDiv, chanCompVal}, 16'h5a5a);
    peek(6'h00, 9'h000);
    chk({1'b0, chanCompDiv, chanCompVal}, 16'h7fff);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end
    else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    oscStatus = 2'h0;
    sfGestDetect = 16'h0000;
    tfGestDetect = 8'h00;
    mapSel = 6'h00;
    chanSel = 9'h000;
    errTotal = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    scnReset();
    scnGesture();
    scnMap();
    scnThr();
    scnCounts();
    scnEng();
    scnComp();
    wrapUp();
  end
endmodule
